// File: hdl/ddc_tap_line.sv
/*
 * Tapped delay line: a shift register of the sampled reference clock,
 * one pclk per tap. Assumes the input is already synchronous to pclk.
 */
`timescale 1ns/1ps
`default_nettype none
module ddc_tap_line #(
    parameter int LEN = 128
) (
    // Clock and reset
    input  wire logic           pclk,
    input  wire logic           presetn,
    // Line
    input  wire logic           din,
    output logic      [LEN-1:0] taps
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            taps <= '0;
        end else begin
            taps <= {taps[LEN-2:0], din};
        end
    end
endmodule : ddc_tap_line
`default_nettype wire

// File: hdl/ddc_top.sv
/*
 * Digital control of a delay-locked loop: bang-bang delay arithmetic,
 * slave update latch, tap selection, fine shift, divider, duty-cycle
 * correction, lock detect, peer Gray/increment chaining, APB registers
 * and interrupt. Assumes all DLL inputs are synchronous to pclk.
 */
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ddc_top #(
    parameter int LEN = ddc_pkg::LINE_LEN
) (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // APB slave
    input  wire logic [7:0] paddr,
    input  wire logic       psel,
    input  wire logic       penable,
    input  wire logic       pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic            pready,
    output logic            pslverr,
    output logic            irq,
    // Loop inputs
    input  wire logic       reference_clock_in,
    input  wire logic       feedback_clock_in,
    input  wire logic       delay_reset_n,
    input  wire logic       code_freeze,
    input  wire logic       code_update_enable,
    input  wire logic       peer_increment_in,
    input  wire logic [5:0] peer_gray_code_in,
    // Loop outputs
    output logic      [5:0] delay_code_bus,
    output logic      [5:0] slave_setting,
    output logic            primary_clock_out,
    output logic            secondary_clock_out,
    output logic            delay_locked,
    output logic            peer_increment_out,
    output logic      [5:0] peer_gray_code_out,
    output logic            code_mismatch_flag
);
    localparam int IDX_W  = ddc_pkg::IDX_W;
    localparam int CTRL_W = ddc_pkg::CTRL_W;
    localparam int IRQ_W  = ddc_pkg::IRQ_W;
    ddc_pkg::ddc_ctrl_t ctrl_q;
    ddc_pkg::ddc_upd_t  upd_q;
    logic [5:0]         code_q, setting_q;
    logic               ref_q, ref_prev_q, fb_q, ref_rise, step_up, step_down;
    logic               last_up_q, lock_q, lock_prev_q, upd_pulse_q;
    logic [2:0]         rev_q, run_q;
    logic [LEN-1:0]     taps;
    logic [ddc_pkg::PER_W-1:0] per_cnt_q, half_q;
    logic [2:0]         fine_add;
    logic [ddc_pkg::IDX_W-1:0] idx [2];
    logic [1:0]         src_q, dcc_q, shaped;
    logic [ddc_pkg::PER_W-1:0] dcc_cnt_q [2];
    logic               shaped_prev_q;
    logic [1:0]         div_q;
    logic [ddc_pkg::IRQ_W-1:0] stat_q, mask_q, events;
    logic               setup, access;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Clock sampling; inputs are synchronous, so one stage suffices
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_q      <= 1'b0;
            ref_prev_q <= 1'b0;
            fb_q       <= 1'b0;
        end else begin
            ref_q      <= reference_clock_in;
            ref_prev_q <= ref_q;
            fb_q       <= feedback_clock_in;
        end
    end
    assign ref_rise = ref_q & ~ref_prev_q;
    // Feedback already high at the reference edge: it is early, add delay
    assign step_up   = ref_rise & fb_q & (code_q != ddc_pkg::CODE_MAX) &
                       ~code_freeze & ~ctrl_q.time_ref;
    assign step_down = ref_rise & ~fb_q & (code_q != 6'h00) &
                       ~code_freeze & ~ctrl_q.time_ref;

    // Delay arithmetic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            code_q <= ddc_pkg::CODE_INIT;
        end else if (!delay_reset_n) begin
            code_q <= ddc_pkg::CODE_INIT;
        end else if (code_freeze) begin
            code_q <= code_q;
        end else if (ctrl_q.time_ref) begin
            code_q <= ddc_pkg::gray_to_bin(peer_gray_code_in);
        end else if (step_up) begin
            code_q <= code_q + 6'h01;
        end else if (step_down) begin
            code_q <= code_q - 6'h01;
        end
    end

    // Lock detect: steady dithering means aligned, a long run means lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_up_q <= 1'b0;
            rev_q     <= 3'h0;
            run_q     <= 3'h0;
            lock_q    <= 1'b0;
        end else if (!delay_reset_n) begin
            rev_q  <= 3'h0;
            run_q  <= 3'h0;
            lock_q <= 1'b0;
        end else if (step_up || step_down) begin
            last_up_q <= step_up;
            if (step_up != last_up_q) begin
                run_q <= 3'h0;
                if (rev_q == ddc_pkg::LOCK_REVERSALS - 3'h1) begin
                    lock_q <= 1'b1;
                end else begin
                    rev_q <= rev_q + 3'h1;
                end
            end else begin
                rev_q <= 3'h0;
                if (run_q == ddc_pkg::LOSE_RUN - 3'h1) begin
                    lock_q <= 1'b0;
                end else begin
                    run_q <= run_q + 3'h1;
                end
            end
        end
    end

    // Slave update: two consecutive enable cycles latch the bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upd_q       <= ddc_pkg::UPD_IDLE;
            setting_q   <= ddc_pkg::CODE_INIT;
            upd_pulse_q <= 1'b0;
        end else if (!delay_reset_n) begin
            upd_q       <= ddc_pkg::UPD_IDLE;
            setting_q   <= ddc_pkg::CODE_INIT;
            upd_pulse_q <= 1'b0;
        end else begin
            upd_pulse_q <= 1'b0;
            case (upd_q)
                ddc_pkg::UPD_IDLE: begin
                    if (code_update_enable) upd_q <= ddc_pkg::UPD_ARMED;
                end
                ddc_pkg::UPD_ARMED: begin
                    if (code_update_enable) begin
                        setting_q   <= code_q;
                        upd_pulse_q <= 1'b1;
                        upd_q       <= ddc_pkg::UPD_DONE;
                    end else begin
                        upd_q <= ddc_pkg::UPD_IDLE;
                    end
                end
                ddc_pkg::UPD_DONE: begin
                    if (!code_update_enable) upd_q <= ddc_pkg::UPD_IDLE;
                end
                default: upd_q <= ddc_pkg::UPD_IDLE;
            endcase
        end
    end

    // Loop-facing outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            delay_code_bus     <= ddc_pkg::CODE_INIT;
            slave_setting      <= ddc_pkg::CODE_INIT;
            // Gray of the reset code, so peers never see a code that was not held
            peer_gray_code_out <= ddc_pkg::CODE_INIT ^ (ddc_pkg::CODE_INIT >> 1);
            code_mismatch_flag <= 1'b0;
            peer_increment_out <= 1'b0;
            delay_locked       <= 1'b0;
        end else begin
            delay_code_bus     <= code_q;
            slave_setting      <= setting_q;
            peer_gray_code_out <= code_q ^ (code_q >> 1);
            code_mismatch_flag <= (code_q != setting_q);
            // Passed along a chain in time reference mode
            peer_increment_out <= ctrl_q.time_ref ? peer_increment_in : step_up;
            delay_locked       <= lock_q;
        end
    end

    ddc_tap_line #(.LEN(LEN)) u_line (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (ref_q),
        .taps    (taps)
    );

    // Reference period, for duty-cycle correction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            per_cnt_q <= '0;
            half_q    <= '0;
        end else if (ref_rise) begin
            per_cnt_q <= '0;
            half_q    <= (per_cnt_q + 8'h01) >> 1;
        end else if (per_cnt_q != 8'hff) begin
            per_cnt_q <= per_cnt_q + 8'h01;
        end
    end

    always_comb begin
        case (ctrl_q.fine_sel)
            ddc_pkg::FINE_45: fine_add = ddc_pkg::FINE_TAPS_45;
            ddc_pkg::FINE_22: fine_add = ddc_pkg::FINE_TAPS_22;
            ddc_pkg::FINE_11: fine_add = ddc_pkg::FINE_TAPS_11;
            default:          fine_add = 3'h0;
        endcase
    end
    // Each output picks its own tap relative to the loop code
    assign idx[0] = IDX_W'(code_q) + IDX_W'(ctrl_q.prim_tap);
    assign idx[1] = IDX_W'(code_q) + IDX_W'(ctrl_q.sec_tap) + IDX_W'(fine_add);

    for (genvar i = 0; i < 2; i++) begin : g_shape
        logic dcc_en;
        assign dcc_en = (i == 0) ? ctrl_q.dcc_prim : ctrl_q.dcc_sec;
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                src_q[i]     <= 1'b0;
                dcc_q[i]     <= 1'b0;
                dcc_cnt_q[i] <= '0;
            end else begin
                src_q[i] <= taps[idx[i]];
                // Rebuild a 50 % high time from the measured period
                if (taps[idx[i]] && !src_q[i] && half_q != 8'h00) begin
                    dcc_q[i]     <= 1'b1;
                    dcc_cnt_q[i] <= half_q - 8'h01;
                end else if (dcc_cnt_q[i] != 8'h00) begin
                    dcc_cnt_q[i] <= dcc_cnt_q[i] - 8'h01;
                end else begin
                    dcc_q[i] <= 1'b0;
                end
            end
        end
        assign shaped[i] = dcc_en ? dcc_q[i] : src_q[i];
    end

    // Secondary divider and clock outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shaped_prev_q       <= 1'b0;
            div_q               <= 2'h0;
            primary_clock_out   <= 1'b0;
            secondary_clock_out <= 1'b0;
        end else begin
            shaped_prev_q     <= shaped[1];
            primary_clock_out <= shaped[0];
            if (shaped[1] && !shaped_prev_q) div_q <= div_q + 2'h1;
            case (ctrl_q.div_sel)
                ddc_pkg::DIV_2: secondary_clock_out <= div_q[0];
                ddc_pkg::DIV_4: secondary_clock_out <= div_q[1];
                default:        secondary_clock_out <= shaped[1];
            endcase
        end
    end

    // APB: no wait state, answer registered in the setup cycle
    assign setup  = psel & ~penable;
    assign access = psel & penable & pready;
    assign events = {upd_pulse_q, lock_prev_q & ~lock_q, lock_q & ~lock_prev_q};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~(paddr inside {ddc_pkg::ADDR_CTRL, ddc_pkg::ADDR_STATUS,
                                   ddc_pkg::ADDR_IRQ_STAT, ddc_pkg::ADDR_IRQ_MASK});
            prdata  <= 32'h0000_0000;
            if (setup && !pwrite) begin
                case (paddr)
                    ddc_pkg::ADDR_CTRL:     prdata <= 32'(ctrl_q);
                    ddc_pkg::ADDR_STATUS:   prdata <= 32'(ddc_pkg::ddc_status_t'(
                                               {code_mismatch_flag, lock_q, setting_q, code_q}));
                    ddc_pkg::ADDR_IRQ_STAT: prdata <= 32'(stat_q);
                    ddc_pkg::ADDR_IRQ_MASK: prdata <= 32'(mask_q);
                    default:                prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q      <= ddc_pkg::CTRL_RESET;
            mask_q      <= ddc_pkg::IRQ_RESET;
            stat_q      <= ddc_pkg::IRQ_RESET;
            lock_prev_q <= 1'b0;
            irq         <= 1'b0;
        end else begin
            lock_prev_q <= lock_q;
            if (access && pwrite && paddr == ddc_pkg::ADDR_CTRL) ctrl_q <= pwdata[CTRL_W-1:0];
            if (access && pwrite && paddr == ddc_pkg::ADDR_IRQ_MASK) mask_q <= pwdata[IRQ_W-1:0];
            // A new event wins over a simultaneous write-one clear
            if (access && pwrite && paddr == ddc_pkg::ADDR_IRQ_STAT) begin
                stat_q <= (stat_q & ~pwdata[IRQ_W-1:0]) | events;
            end else begin
                stat_q <= stat_q | events;
            end
            irq <= |(stat_q & mask_q);
        end
    end

    freeze_hold_a: assert property (code_freeze && delay_reset_n ##1 delay_reset_n
        |-> $stable(code_q)) else $error("code moved while frozen");
    update_latch_a: assert property (upd_q == ddc_pkg::UPD_ARMED && code_update_enable
        && delay_reset_n |=> setting_q == $past(code_q) ##1 code_mismatch_flag == 1'b0
        || !delay_reset_n || code_q != setting_q) else $error("update latch wrong");
    reset_code_a: assert property (!delay_reset_n |=> code_q == ddc_pkg::CODE_INIT
        && !lock_q ##1 !delay_locked) else $error("delay reset not applied");
    gray_out_a: assert property (##1 ddc_pkg::gray_to_bin(peer_gray_code_out)
        == $past(code_q)) else $error("gray output wrong");
    mismatch_flag_a: assert property (code_mismatch_flag
        == (delay_code_bus != slave_setting)) else $error("mismatch flag wrong");
    loop_step_a: assert property (ref_rise && fb_q && !code_freeze && !ctrl_q.time_ref
        && delay_reset_n && code_q != ddc_pkg::CODE_MAX |=> code_q == $past(code_q) + 6'h01)
        else $error("no step toward feedback");
    bus_drive_a: assert property (##1 delay_code_bus == $past(code_q))
        else $error("control bus stale");
    time_ref_a: assert property (ctrl_q.time_ref && !code_freeze && delay_reset_n
        |=> code_q == ddc_pkg::gray_to_bin($past(peer_gray_code_in)))
        else $error("peer code not followed");
    peer_inc_a: assert property (ctrl_q.time_ref && peer_increment_in |=> peer_increment_out)
        else $error("increment not passed on");
    lock_rise_a: assert property ($rose(lock_q) |-> $past(rev_q)
        == ddc_pkg::LOCK_REVERSALS - 3'h1) else $error("lock too early");
    reset_sync_a: assert property (!delay_reset_n |=> code_q == ddc_pkg::CODE_INIT)
        else $error("reset not sampled");

    lock_gain_c: cover property ($rose(delay_locked));
    update_done_c: cover property (upd_pulse_q ##1 !code_mismatch_flag);
    time_ref_c: cover property (ctrl_q.time_ref && $changed(code_q));
    irq_c: cover property ($rose(irq));
endmodule : ddc_top
`default_nettype wire

// File: include/ddc_pkg.sv
/*
 * Constants, register map and carrier types of the delay-locked loop
 * control block. Assumes a single 125 MHz clock (pclk) domain and an
 * APB register port with 32-bit data.
 */
// What this block does
// - Each reference rising edge steps the delay code toward phase alignment of the feedback.
// - The delay code is driven on the control bus that feeds the two slave delay lines.
// - While the freeze input is high and the delay reset input is high, the delay code keeps its present value.
// - Update-enable high for two consecutive cycles latches the control bus into the setting.
// - The delay reset input is active low and sampled on the clock edge.
// - Primary and secondary outputs each pick their own tap of the delay line.
// - The secondary output may be shifted further by 45, 22.5 or 11.25 degrees.
// - The secondary output may be divided by two or by four.
// - Duty-cycle correction is selectable on the primary and on the secondary output.
// - The lock indicator goes high once the delay loop has locked.
// - In time reference mode the code follows a 6-bit Gray code from a peer loop.
// - The own delay code leaves the block as a 6-bit Gray code for peer loops.
// - An increment indicator is received from and driven to peer loops.
// - A mismatch flag is high while the control bus differs from the latched setting.
package ddc_pkg;
    localparam int          CODE_W         = 6;
    localparam logic [5:0]  CODE_INIT      = 6'h20;
    localparam logic [5:0]  CODE_MAX       = 6'h3f;
    localparam int          LINE_LEN       = 128;
    localparam int          IDX_W          = 7;
    localparam int          PER_W          = 8;
    localparam logic [2:0]  FINE_TAPS_45   = 3'h4;
    localparam logic [2:0]  FINE_TAPS_22   = 3'h2;
    localparam logic [2:0]  FINE_TAPS_11   = 3'h1;
    localparam logic [1:0]  FINE_NONE      = 2'h0;
    localparam logic [1:0]  FINE_45        = 2'h1;
    localparam logic [1:0]  FINE_22        = 2'h2;
    localparam logic [1:0]  FINE_11        = 2'h3;
    localparam logic [1:0]  DIV_1          = 2'h0;
    localparam logic [1:0]  DIV_2          = 2'h1;
    localparam logic [1:0]  DIV_4          = 2'h2;
    localparam logic [2:0]  LOCK_REVERSALS = 3'h4;
    localparam logic [2:0]  LOSE_RUN       = 3'h4;
    // Register byte offsets
    localparam logic [7:0]  ADDR_CTRL      = 8'h00;
    localparam logic [7:0]  ADDR_STATUS    = 8'h04;
    localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h08;
    localparam logic [7:0]  ADDR_IRQ_MASK  = 8'h0c;
    localparam int          CTRL_W         = 15;
    localparam logic [14:0] CTRL_RESET     = 15'h0000;
    localparam int          IRQ_W          = 3;
    localparam logic [2:0]  IRQ_RESET      = 3'h0;
    localparam int          IRQ_LOCK_GAIN  = 0;
    localparam int          IRQ_LOCK_LOSS  = 1;
    localparam int          IRQ_UPDATE     = 2;

    typedef struct packed {
        logic       dcc_sec;
        logic       dcc_prim;
        logic [1:0] div_sel;
        logic [1:0] fine_sel;
        logic [3:0] sec_tap;
        logic [3:0] prim_tap;
        logic       time_ref;
    } ddc_ctrl_t;

    typedef struct packed {
        logic       mismatch;
        logic       locked;
        logic [5:0] setting;
        logic [5:0] code;
    } ddc_status_t;

    typedef enum logic [1:0] {
        UPD_IDLE  = 2'b00,
        UPD_ARMED = 2'b01,
        UPD_DONE  = 2'b10
    } ddc_upd_t;

    function automatic logic [5:0] gray_to_bin(input logic [5:0] g);
        logic [5:0] b;
        b[5] = g[5];
        for (int i = 4; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction : gray_to_bin
endpackage : ddc_pkg

// File: test/ddc_far_model.sv
/*
 * Far side of the loop: reference clock, feedback net and a peer loop.
 * Assumes the bench picks the feedback source and the peer values.
 */
`timescale 1ns/1ps
`default_nettype none
module ddc_far_model (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Choices from the bench
    input  wire logic [1:0] fb_mode,
    input  wire logic [5:0] peer_gray_set,
    input  wire logic       peer_inc_set,
    input  wire logic       loop_clk,
    // Toward the block
    output logic            reference_clock_in,
    output logic            feedback_clock_in,
    output logic      [5:0] peer_gray_code_in,
    output logic            peer_increment_in
);
    logic [3:0] ref_cnt_q;

    // Period of 16 pclk, so one tap is a small phase step
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_cnt_q <= 4'h0;
        end else begin
            ref_cnt_q <= ref_cnt_q + 4'h1;
        end
    end
    assign reference_clock_in = ref_cnt_q[3];

    // Fixed level, or the loop output fed back as a clock net would
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            feedback_clock_in <= 1'b0;
        end else begin
            feedback_clock_in <= (fb_mode == 2'h2) ? loop_clk : fb_mode[0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            peer_gray_code_in <= 6'h00;
            peer_increment_in <= 1'b0;
        end else begin
            peer_gray_code_in <= peer_gray_set;
            peer_increment_in <= peer_inc_set;
        end
    end
endmodule : ddc_far_model
`default_nettype wire

// File: test/ddc_top_tb_top.sv
/*
 * Self-checking bench of ddc_top: registers, loop, freeze, update, chaining, lock.
 * Assumes ddc_far_model as reference, feedback and peer source.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin miscompares++; \
    $display("ERROR %0t: got %h expected %h", $time, (a), (e)); end end
module ddc_top_tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic        delay_reset_n, code_freeze, code_update_enable, delay_locked;
    logic        reference_clock_in, feedback_clock_in, peer_increment_in, peer_inc_set;
    logic        primary_clock_out, secondary_clock_out, peer_increment_out;
    logic        code_mismatch_flag;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, seed;
    logic [5:0]  delay_code_bus, slave_setting, peer_gray_code_in, peer_gray_code_out;
    logic [5:0]  peer_gray_set, bin;
    logic [1:0]  fb_mode;
    logic [32:0] exp_q[$], nxt;
    logic [127:0] ref_hist;
    int          miscompares, tests_run, k, inc_cnt, rises, highs, pi, si;

    ddc_top u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .irq, .reference_clock_in, .feedback_clock_in, .delay_reset_n,
        .code_freeze, .code_update_enable, .peer_increment_in, .peer_gray_code_in,
        .delay_code_bus, .slave_setting, .primary_clock_out, .secondary_clock_out,
        .delay_locked, .peer_increment_out, .peer_gray_code_out, .code_mismatch_flag);
    ddc_far_model u_far (.pclk, .presetn, .fb_mode, .peer_gray_set, .peer_inc_set,
        .loop_clk(primary_clock_out), .reference_clock_in, .feedback_clock_in,
        .peer_gray_code_in, .peer_increment_in);

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(a, 1'b0, 32'h0);
    endtask : rd

    // Secondary rising edges and primary high cycles over 256 clocks
    task automatic measure;
        logic s_prev;
        s_prev = secondary_clock_out;
        rises = 0;
        highs = 0;
        repeat (256) begin
            @(posedge pclk);
            rises += int'(secondary_clock_out & ~s_prev);
            highs += int'(primary_clock_out);
            s_prev = secondary_clock_out;
        end
    endtask : measure

    task automatic end_sim;
        $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    // Read answers are judged here, in issue order
    always @(posedge pclk) begin
        if (peer_increment_out === 1'b1) inc_cnt++;
        ref_hist <= {ref_hist[126:0], reference_clock_in};
        if (psel && penable && pready && !pwrite) begin
            nxt = exp_q.pop_front();
            `CHK({pslverr, prdata}, nxt)
        end
    end

    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        end_sim();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata, peer_gray_set, peer_inc_set} = '0;
        {presetn, code_update_enable, miscompares, tests_run, inc_cnt} = '0;
        {delay_reset_n, code_freeze, fb_mode} = 4'hd;
        seed = 32'hbbff;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        `CHK(delay_code_bus, 6'h20)
        rd(ddc_pkg::ADDR_STATUS, 33'h820);
        seed = xs(seed);
        apb(ddc_pkg::ADDR_CTRL, 1'b1, {17'h0, seed[14:1], 1'b0});
        rd(ddc_pkg::ADDR_CTRL, {18'h0, seed[14:1], 1'b0});
        rd(8'h10, {1'b1, 32'h0});
        repeat (40) @(posedge pclk);
        rd(ddc_pkg::ADDR_STATUS, 33'h820);
        code_freeze <= 1'b0;
        for (k = 0; k < 200 && delay_code_bus !== 6'h23; k++) @(posedge pclk);
        code_freeze <= 1'b1;
        `CHK(delay_code_bus, 6'h23)
        rd(ddc_pkg::ADDR_STATUS, 33'h2823);
        `CHK(inc_cnt, 3)
        // A lone enable cycle must not latch
        code_update_enable <= 1'b1;
        @(posedge pclk);
        code_update_enable <= 1'b0;
        apb(ddc_pkg::ADDR_IRQ_MASK, 1'b1, 32'h4);
        rd(ddc_pkg::ADDR_STATUS, 33'h2823);
        code_update_enable <= 1'b1;
        repeat (2) @(posedge pclk);
        code_update_enable <= 1'b0;
        repeat (5) @(posedge pclk);
        `CHK(slave_setting, 6'h23)
        `CHK(irq, 1'b1)
        rd(ddc_pkg::ADDR_STATUS, 33'h08e3);
        apb(ddc_pkg::ADDR_IRQ_STAT, 1'b1, 32'h4);
        repeat (3) @(posedge pclk);
        `CHK(irq, 1'b0)
        apb(ddc_pkg::ADDR_CTRL, 1'b1, 32'h1);
        code_freeze <= 1'b0;
        for (k = 0; k < 8; k++) begin
            seed = xs(seed);
            bin = seed[5:0];
            peer_gray_set <= bin ^ (bin >> 1);
            peer_inc_set <= seed[6];
            repeat (4) @(posedge pclk);
            `CHK(delay_code_bus, bin)
            `CHK(peer_gray_code_out, bin ^ (bin >> 1))
            `CHK(peer_increment_out, seed[6])
        end
        // Code now held at bin; one tap is one clock, plus three stages of pipeline
        seed = xs(seed);
        apb(ddc_pkg::ADDR_CTRL, 1'b1, {21'h0, seed[10:1], 1'b1});
        pi = bin + seed[4:1] + 3;
        si = bin + seed[8:5] + 3;
        case (seed[10:9])
            ddc_pkg::FINE_45: si += ddc_pkg::FINE_TAPS_45;
            ddc_pkg::FINE_22: si += ddc_pkg::FINE_TAPS_22;
            ddc_pkg::FINE_11: si += ddc_pkg::FINE_TAPS_11;
            default:          si += 0;
        endcase
        repeat (100) @(posedge pclk);
        for (k = 0; k < 32; k++) begin
            @(posedge pclk);
            `CHK(primary_clock_out, ref_hist[pi])
            `CHK(secondary_clock_out, ref_hist[si])
        end
        apb(ddc_pkg::ADDR_CTRL, 1'b1, {17'h0, 2'h1, ddc_pkg::DIV_2, 10'h0, 1'b1});
        repeat (64) @(posedge pclk);
        measure();
        `CHK(rises, 8)
        `CHK(highs, 128)
        apb(ddc_pkg::ADDR_CTRL, 1'b1, {17'h0, 2'h0, ddc_pkg::DIV_4, 10'h0, 1'b1});
        repeat (64) @(posedge pclk);
        measure();
        `CHK(rises, 4)
        code_freeze <= 1'b1;
        apb(ddc_pkg::ADDR_CTRL, 1'b1, 32'h0);
        delay_reset_n <= 1'b0;
        @(posedge pclk);
        delay_reset_n <= 1'b1;
        rd(ddc_pkg::ADDR_STATUS, 33'h820);
        apb(ddc_pkg::ADDR_IRQ_MASK, 1'b1, 32'h1);
        fb_mode <= 2'h2;
        code_freeze <= 1'b0;
        for (k = 0; k < 1500 && delay_locked !== 1'b1; k++) @(posedge pclk);
        `CHK(delay_locked, 1'b1)
        repeat (4) @(posedge pclk);
        `CHK(irq, 1'b1)
        delay_reset_n <= 1'b0;
        repeat (3) @(posedge pclk);
        `CHK(delay_locked, 1'b0)
        end_sim();
    end
endmodule : ddc_top_tb_top
`default_nettype wire
